//--- sfp_pkg.sv
// package: register map, field layout and constants of the sample fifo pwm
package sfp_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;  // control
  localparam logic [11:0] OFF_STATUS = 12'h004;  // sticky event status, write one to clear
  localparam logic [11:0] OFF_MASK   = 12'h008;  // interrupt mask
  localparam logic [11:0] OFF_SAMPLE = 12'h00C;  // sample fifo write port
  localparam logic [11:0] OFF_PERIOD = 12'h010;  // period register
  localparam logic [11:0] OFF_COUNT  = 12'h014;  // live counter readback
  localparam logic [11:0] OFF_PRESC  = 12'h018;  // prescaler divide value

  // control fields
  localparam int CTRL_EN_BIT   = 0;  // modulator enable
  localparam int CTRL_SRC_LSB  = 1;  // clock_source_select, two bits
  localparam int CTRL_SRC_W    = 2;
  localparam int CTRL_POL_BIT  = 3;  // output polarity invert

  // widths
  localparam int CNT_W  = 16;  // counter and sample width
  localparam int FIFO_D = 4;   // fifo depth
  localparam int PTR_W  = 2;   // fifo index width
  localparam int LVL_W  = 3;   // fifo level width
  localparam int PSC_W  = 12;  // prescaler width
  localparam int NIRQ   = 4;   // interrupt lines

  // status bit positions
  localparam int ST_ROOM  = 0;  // fifo has room
  localparam int ST_ROLL  = 1;  // period rollover
  localparam int ST_CMP   = 2;  // compare match
  localparam int ST_UNDER = 3;  // rollover with fifo empty

  // reset values
  localparam logic [15:0] PERIOD_RST = 16'hFFFE;
  localparam logic [11:0] PRESC_RST  = 12'h000;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  // clock source selection codes
  typedef enum logic [1:0] {
    SFP_SRC_OFF    = 2'h0,
    SFP_SRC_IPG    = 2'h1,
    SFP_SRC_HIGH   = 2'h2,
    SFP_SRC_LOWREF = 2'h3
  } sfp_src_e;
endpackage : sfp_pkg

//--- sfp_fifo.sv
// file: four by sixteen sample fifo held in flip-flops
`timescale 1ns/1ns
module sfp_fifo (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // filling side
  input  wire logic                      wr_valid,
  output logic                           wr_ready,
  input  wire logic [sfp_pkg::CNT_W-1:0] wr_data,
  // draining side
  output logic                           rd_valid,
  input  wire logic                      rd_ready,
  output logic [sfp_pkg::CNT_W-1:0]      rd_data,
  // fill level
  output logic [sfp_pkg::LVL_W-1:0]      level
);
  logic [sfp_pkg::CNT_W-1:0] mem [sfp_pkg::FIFO_D];  // sample storage
  logic [sfp_pkg::PTR_W-1:0] wptr;                   // write index
  logic [sfp_pkg::PTR_W-1:0] rptr;                   // read index
  logic [sfp_pkg::PTR_W-1:0] next_wptr;
  logic [sfp_pkg::PTR_W-1:0] next_rptr;
  logic [sfp_pkg::LVL_W-1:0] next_level;
  logic                      do_wr;
  logic                      do_rd;

  // honest flags straight from the level
  assign wr_ready = (level != sfp_pkg::LVL_W'(sfp_pkg::FIFO_D));
  assign rd_valid = (level != '0);
  assign rd_data  = mem[rptr];
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_valid && rd_ready;

  // pointer and level next state
  always_comb begin
    next_wptr  = do_wr ? wptr + 1'b1 : wptr;
    next_rptr  = do_rd ? rptr + 1'b1 : rptr;
    next_level = level;
    if (do_wr && !do_rd) begin
      next_level = level + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_level = level - 1'b1;
    end
  end

  // pointer and level registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr  <= '0;
      rptr  <= '0;
      level <= '0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      level <= next_level;
    end
  end

  // storage, one entry per flip-flop group; data needs no reset
  genvar gi;
  for (gi = 0; gi < sfp_pkg::FIFO_D; gi++) begin : g_mem
    always_ff @(posedge clk) begin
      if (do_wr && wptr == sfp_pkg::PTR_W'(gi)) begin
        mem[gi] <= wr_data;
      end
    end
  end
endmodule : sfp_fifo

//--- sfp_presc.sv
// file: source selection and prescaler producing a one-cycle count tick
`timescale 1ns/1ns
module sfp_presc (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // control
  input  wire logic                      run,
  input  wire logic [1:0]                src_sel,
  input  wire logic [sfp_pkg::PSC_W-1:0] div,
  // source ticks, already synchronous to clk
  input  wire logic                      tick_high,
  input  wire logic                      tick_lowref,
  // count enable pulse
  output logic                           tick
);
  logic [sfp_pkg::PSC_W-1:0] cnt;       // prescaler counter
  logic [sfp_pkg::PSC_W-1:0] next_cnt;
  logic                      next_tick;
  logic                      src_tick;  // selected source edge

  // pick the feeding source; the bus clock ticks on every edge
  always_comb begin
    unique case (sfp_pkg::sfp_src_e'(src_sel))
      sfp_pkg::SFP_SRC_OFF:    src_tick = 1'b0;
      sfp_pkg::SFP_SRC_IPG:    src_tick = 1'b1;
      sfp_pkg::SFP_SRC_HIGH:   src_tick = tick_high;
      sfp_pkg::SFP_SRC_LOWREF: src_tick = tick_lowref;
    endcase
  end

  // divide the source by div+1
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (src_tick) begin
      if (cnt >= div) begin
        next_cnt  = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // prescaler registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : sfp_presc

//--- sfp_top.sv
// file: apb slave, counter and output stage of the sample fifo pwm
`timescale 1ns/1ns
module sfp_top (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // source ticks from the clock controller unit, synchronous to clk
  input  wire logic                      tick_high,
  input  wire logic                      tick_lowref,
  input  wire logic                      low_power,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // pulse output pin
  output logic                           pulse_output_pin,
  // interrupts
  output logic [sfp_pkg::NIRQ-1:0]       irq_lines,
  output logic                           irq
);
  // register state
  logic                          enable;        // modulator running
  logic [1:0]                    src_sel;       // clock_source_select
  logic                          invert;        // output polarity
  logic [sfp_pkg::CNT_W-1:0]     period;        // period register
  logic [sfp_pkg::PSC_W-1:0]     presc;         // prescaler divide
  logic [sfp_pkg::NIRQ-1:0]      status;        // sticky events
  logic [sfp_pkg::NIRQ-1:0]      mask;          // interrupt mask
  logic [31:0]                   rdata_q;       // registered read data
  logic                          next_enable;
  logic [1:0]                    next_src_sel;
  logic                          next_invert;
  logic [sfp_pkg::CNT_W-1:0]     next_period;
  logic [sfp_pkg::PSC_W-1:0]     next_presc;
  logic [sfp_pkg::NIRQ-1:0]      next_status;
  logic [sfp_pkg::NIRQ-1:0]      next_mask;
  logic [31:0]                   next_rdata;
  // counter and output state
  logic [sfp_pkg::CNT_W-1:0]     count;         // main counter
  logic [sfp_pkg::CNT_W-1:0]     duty;          // active sample
  logic                          pulse_output;  // internal level before polarity
  logic [sfp_pkg::CNT_W-1:0]     next_count;
  logic [sfp_pkg::CNT_W-1:0]     next_duty;
  logic                          next_pulse;
  // fifo hookup
  logic                          f_wr_ready;
  logic                          f_rd_valid;
  logic                          f_rd_ready;
  logic [sfp_pkg::CNT_W-1:0]     f_rd_data;
  logic [sfp_pkg::LVL_W-1:0]     f_level;
  // events
  logic                          tick;          // prescaled count enable
  logic                          rollover;      // counter wraps this tick
  logic                          cmp_hit;       // next count meets duty
  logic [sfp_pkg::NIRQ-1:0]      events;
  // bus decode
  logic                          acc;           // access phase
  logic                          wr_acc;
  logic                          wr_ctrl;
  logic                          wr_stat;
  logic                          wr_mask;
  logic                          wr_samp;
  logic                          wr_per;
  logic                          wr_psc;
  logic                          mapped;

  // address match used for every register
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // single-cycle access phase: ready is always high, answer in the access cycle
  assign acc     = psel && penable;
  assign wr_acc  = acc && pwrite;
  assign wr_ctrl = wr_acc && hit(paddr, sfp_pkg::OFF_CTRL);
  assign wr_stat = wr_acc && hit(paddr, sfp_pkg::OFF_STATUS);
  assign wr_mask = wr_acc && hit(paddr, sfp_pkg::OFF_MASK);
  assign wr_samp = wr_acc && hit(paddr, sfp_pkg::OFF_SAMPLE);
  assign wr_per  = wr_acc && hit(paddr, sfp_pkg::OFF_PERIOD);
  assign wr_psc  = wr_acc && hit(paddr, sfp_pkg::OFF_PRESC);
  assign mapped  = hit(paddr, sfp_pkg::OFF_CTRL)   || hit(paddr, sfp_pkg::OFF_STATUS) ||
                   hit(paddr, sfp_pkg::OFF_MASK)   || hit(paddr, sfp_pkg::OFF_SAMPLE) ||
                   hit(paddr, sfp_pkg::OFF_PERIOD) || hit(paddr, sfp_pkg::OFF_COUNT)  ||
                   hit(paddr, sfp_pkg::OFF_PRESC);
  assign pready  = 1'b1;
  // unmapped access or a sample write into a full fifo answers with an error
  assign pslverr = acc && (!mapped || (wr_samp && !f_wr_ready));
  assign prdata  = rdata_q;

  // sample fifo between bus and counter
  sfp_fifo u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_valid (wr_samp),
    .wr_ready (f_wr_ready),
    .wr_data  (pwdata[sfp_pkg::CNT_W-1:0]),
    .rd_valid (f_rd_valid),
    .rd_ready (f_rd_ready),
    .rd_data  (f_rd_data),
    .level    (f_level)
  );

  // source select and prescaler; low reference and high ticks ignore low_power,
  // so the block keeps counting from them while the functional clock is gated
  sfp_presc u_presc (
    .clk         (clk),
    .rst_n       (rst_n),
    .run         (enable),
    .src_sel     (src_sel),
    .div         (presc),
    .tick_high   (tick_high),
    .tick_lowref (tick_lowref),
    .tick        (tick)
  );

  // rollover and compare, evaluated on prescaled ticks only
  assign rollover   = tick && (count >= period);
  // match looks one count ahead so the pin is already low while count equals duty
  assign cmp_hit    = tick && !rollover && (sfp_pkg::CNT_W'(count + 1'b1) == duty);
  assign f_rd_ready = rollover;
  assign events[sfp_pkg::ST_ROOM]  = f_wr_ready;
  assign events[sfp_pkg::ST_ROLL]  = rollover;
  assign events[sfp_pkg::ST_CMP]   = cmp_hit;
  assign events[sfp_pkg::ST_UNDER] = rollover && !f_rd_valid;

  // counter and output next state
  always_comb begin
    next_count = count;
    next_duty  = duty;
    next_pulse = pulse_output;
    if (!enable) begin
      // disabled: output parked inactive and counter cleared
      next_count = '0;
      next_pulse = 1'b0;
    end else if (rollover) begin
      next_count = '0;
      next_pulse = 1'b1;
      // keep the last duty when the fifo has run dry
      if (f_rd_valid) begin
        next_duty = f_rd_data;
      end
    end else if (cmp_hit) begin
      next_pulse = 1'b0;
      next_count = count + 1'b1;
    end else if (tick) begin
      next_count = count + 1'b1;
    end
  end

  // counter and output registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count        <= '0;
      duty         <= '0;
      pulse_output <= 1'b0;
    end else begin
      count        <= next_count;
      duty         <= next_duty;
      pulse_output <= next_pulse;
    end
  end

  // register file next state
  always_comb begin
    next_enable  = enable;
    next_src_sel = src_sel;
    next_invert  = invert;
    next_period  = period;
    next_presc   = presc;
    next_mask    = mask;
    next_rdata   = rdata_q;
    if (wr_ctrl) begin
      next_enable = pwdata[sfp_pkg::CTRL_EN_BIT];
      next_invert = pwdata[sfp_pkg::CTRL_POL_BIT];
      // source is only taken while stopped and staying stopped
      if (!enable && !pwdata[sfp_pkg::CTRL_EN_BIT]) begin
        next_src_sel = pwdata[sfp_pkg::CTRL_SRC_LSB +: sfp_pkg::CTRL_SRC_W];
      end
    end
    if (wr_per) begin
      next_period = pwdata[sfp_pkg::CNT_W-1:0];
    end
    if (wr_psc) begin
      next_presc = pwdata[sfp_pkg::PSC_W-1:0];
    end
    if (wr_mask) begin
      next_mask = pwdata[sfp_pkg::NIRQ-1:0];
    end
    // set wins over write-one-to-clear
    next_status = (status & ~(wr_stat ? pwdata[sfp_pkg::NIRQ-1:0] : '0)) | events;
    // read mux, captured in the setup cycle so data is ready in access phase
    if (psel && !penable && !pwrite) begin
      next_rdata = 32'h0000_0000;
      if (hit(paddr, sfp_pkg::OFF_CTRL)) begin
        next_rdata[sfp_pkg::CTRL_EN_BIT] = enable;
        next_rdata[sfp_pkg::CTRL_SRC_LSB +: sfp_pkg::CTRL_SRC_W] = src_sel;
        next_rdata[sfp_pkg::CTRL_POL_BIT] = invert;
      end else if (hit(paddr, sfp_pkg::OFF_STATUS)) begin
        next_rdata[sfp_pkg::NIRQ-1:0] = status;
      end else if (hit(paddr, sfp_pkg::OFF_MASK)) begin
        next_rdata[sfp_pkg::NIRQ-1:0] = mask;
      end else if (hit(paddr, sfp_pkg::OFF_SAMPLE)) begin
        // sample reads show the fifo level
        next_rdata[sfp_pkg::LVL_W-1:0] = f_level;
      end else if (hit(paddr, sfp_pkg::OFF_PERIOD)) begin
        next_rdata[sfp_pkg::CNT_W-1:0] = period;
      end else if (hit(paddr, sfp_pkg::OFF_COUNT)) begin
        next_rdata[sfp_pkg::CNT_W-1:0] = count;
      end else if (hit(paddr, sfp_pkg::OFF_PRESC)) begin
        next_rdata[sfp_pkg::PSC_W-1:0] = presc;
      end
    end
  end

  // register file flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable  <= 1'b0;
      src_sel <= sfp_pkg::SFP_SRC_IPG;
      invert  <= 1'b0;
      period  <= sfp_pkg::PERIOD_RST;
      presc   <= sfp_pkg::PRESC_RST;
      mask    <= sfp_pkg::MASK_RST;
      status  <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      enable  <= next_enable;
      src_sel <= next_src_sel;
      invert  <= next_invert;
      period  <= next_period;
      presc   <= next_presc;
      mask    <= next_mask;
      status  <= next_status;
      rdata_q <= next_rdata;
    end
  end

  // polarity sits after the flip-flop; low_power is advisory only here since
  // the single clk stands in for every source, so nothing here is gated by it
  assign pulse_output_pin = pulse_output ^ invert;
  assign irq_lines        = status & mask;
  assign irq              = |irq_lines;
endmodule : sfp_top

//--- sfp_assertions.sv
// checker: bus and output relations at the ports of the sample fifo pwm top
`timescale 1ns/1ns
module sfp_assertions (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst_n,
  // apb slave
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // pin and interrupts
  input wire logic                      pulse_output_pin,
  input wire logic [sfp_pkg::NIRQ-1:0]  irq_lines,
  input wire logic                      irq
);
  // one domain, so clock and disable are given once
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // access cycle helpers
  wire logic acc = psel && penable;
  wire logic hole = (paddr > sfp_pkg::OFF_PRESC) && (paddr[1:0] == 2'h0);

  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("pready low in access cycle");
  property p_err_phase; pslverr |-> acc; endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("pslverr outside access cycle");
  property p_hole_err; acc && hole |-> pslverr; endproperty
  a_hole_err: assert property (p_hole_err)
    else $error("unmapped access not refused");
  property p_hole_rd; acc && hole && !pwrite |-> prdata == 32'h0; endproperty
  a_hole_rd: assert property (p_hole_rd)
    else $error("unmapped read not zero");
  property p_map_rd; acc && !pwrite && !hole && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_map_rd: assert property (p_map_rd)
    else $error("mapped read refused");
  property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved outside read setup");
  property p_level; acc && !pwrite && paddr == sfp_pkg::OFF_SAMPLE |-> prdata <= 32'h4; endproperty
  a_level: assert property (p_level)
    else $error("fifo level above depth");
  property p_irq_or; (irq_lines != 4'h0) == irq; endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("irq not the or of its lines");
  property p_mask;
    acc && pwrite && paddr == sfp_pkg::OFF_MASK |=> (irq_lines & ~$past(pwdata[3:0])) == 4'h0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked line still raised");
  property p_disable;
    acc && pwrite && paddr == sfp_pkg::OFF_CTRL && !pwdata[sfp_pkg::CTRL_EN_BIT]
      |-> ##2 pulse_output_pin == $past(pwdata[sfp_pkg::CTRL_POL_BIT], 2);
  endproperty
  a_disable: assert property (p_disable)
    else $error("pin not idle after disable");
endmodule : sfp_assertions

bind sfp_top sfp_assertions u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pulse_output_pin(pulse_output_pin), .irq_lines(irq_lines), .irq(irq));

//--- sfp_ccu_model.sv
// model: clock controller unit making the high and low reference source ticks
`timescale 1ns/1ns
module sfp_ccu_model #(
  parameter int HIGH_DIV = 5,  // core cycles per high clock edge
  parameter int LOW_DIV  = 7   // scaled-down low reference rate, keeps the run short
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // source ticks, one cycle wide
  output logic      tick_high,
  output logic      tick_lowref
);
  int hcnt;  // high source divider
  int lcnt;  // low reference divider
  // sources run free, low power or not, so the pwm keeps counting on them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt        <= 0;
      lcnt        <= 0;
      tick_high   <= 1'b0;
      tick_lowref <= 1'b0;
    end else begin
      hcnt        <= (hcnt == HIGH_DIV - 1) ? 0 : hcnt + 1;
      lcnt        <= (lcnt == LOW_DIV - 1) ? 0 : lcnt + 1;
      tick_high   <= (hcnt == HIGH_DIV - 1);
      tick_lowref <= (lcnt == LOW_DIV - 1);
    end
  end
endmodule : sfp_ccu_model

//--- tb_sfp_top.sv
// testbench: register, interrupt, fifo and pulse checks of the sample fifo pwm
`timescale 1ns/1ns
module tb_sfp_top;
  typedef struct {int hi; int lo;} sfp_pw_s;  // expected high and low run of one pulse
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, low_power = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pulse_output_pin, irq, tick_high, tick_lowref, last_err, last_pin;
  logic [3:0] irq_lines;
  logic [31:0] rd_q[$];   // expected read data, oldest first
  sfp_pw_s pw_q[$];       // expected pulse shapes, oldest first
  int bad_count = 0, checked = 0, cyc = 0, run_len = 0, seed;
  int per, t;
  bit have_fall = 0;
  logic [15:0] smp[4];

  initial forever #2 clk = ~clk;
  sfp_ccu_model u_ccu (.clk(clk), .rst_n(rst_n), .tick_high(tick_high), .tick_lowref(tick_lowref));
  sfp_top dut (.clk(clk), .rst_n(rst_n), .tick_high(tick_high), .tick_lowref(tick_lowref),
    .low_power(low_power), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_output_pin(pulse_output_pin), .irq_lines(irq_lines), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // one apb transfer; the answer is taken at the rising edge that sees pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      last_err = pslverr;
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic port(input string nm, input logic e, input logic g);
    repeat (3) @(negedge clk);
    chk(nm, e, nm == "pin" ? pulse_output_pin : irq);
  endtask : port
  task automatic drain();
    while (pw_q.size() != 0) @(posedge clk);
  endtask : drain

  // read watcher: compares each read answer with the oldest note
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() != 0) begin
      chk("prdata", rd_q.pop_front(), prdata);
    end
  end
  // pulse watcher: high run checked at the fall, low run at the next rise
  always @(negedge clk) begin
    if (pulse_output_pin !== last_pin) begin
      if (pulse_output_pin === 1'b0 && pw_q.size() != 0) begin
        chk("high run", pw_q[0].hi, run_len);
        have_fall = 1;
      end else if (pulse_output_pin === 1'b1 && have_fall) begin
        chk("low run", pw_q.pop_front().lo, run_len);
        have_fall = 0;
      end
      run_len = 1;
    end else run_len++;
    last_pin = pulse_output_pin;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    seed = $urandom(32'h710D);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(sfp_pkg::OFF_CTRL, 32'h2);
    rd(sfp_pkg::OFF_STATUS, 32'h1);
    rd(sfp_pkg::OFF_MASK, 32'h0);
    rd(sfp_pkg::OFF_PERIOD, 32'hFFFE);
    rd(sfp_pkg::OFF_COUNT, 32'h0);
    rd(sfp_pkg::OFF_PRESC, 32'h0);
    rd(sfp_pkg::OFF_SAMPLE, 32'h0);
    rd(12'h01C, 32'h0);
    chk("unmapped err", 1'b1, last_err);
    wr(sfp_pkg::OFF_PERIOD, 32'hABCD_FFFF);
    rd(sfp_pkg::OFF_PERIOD, 32'hFFFF);
    $display("test reset_values done");
    wr(sfp_pkg::OFF_MASK, 32'h1);
    port("irq", 1'b1, irq);
    wr(sfp_pkg::OFF_MASK, 32'h0);
    port("irq", 1'b0, irq);
    per = $urandom_range(12, 4);
    for (int i = 0; i < 4; i++) begin
      smp[i] = 16'($urandom_range(per - 1, 1));
      wr(sfp_pkg::OFF_SAMPLE, {16'h0, smp[i]});
      chk("push err", 1'b0, last_err);
      pw_q.push_back('{smp[i], per + 1 - smp[i]});
    end
    pw_q.push_back('{smp[3], per + 1 - smp[3]});  // underrun keeps the last duty
    wr(sfp_pkg::OFF_SAMPLE, 32'h1);
    chk("full err", 1'b1, last_err);
    rd(sfp_pkg::OFF_SAMPLE, 32'h4);
    wr(sfp_pkg::OFF_STATUS, 32'h1);
    rd(sfp_pkg::OFF_STATUS, 32'h0);
    $display("test fifo_fill done");
    wr(sfp_pkg::OFF_PERIOD, 32'(per));
    wr(sfp_pkg::OFF_CTRL, 32'h3);
    wr(sfp_pkg::OFF_CTRL, 32'h5);
    rd(sfp_pkg::OFF_CTRL, 32'h3);
    drain();
    wr(sfp_pkg::OFF_MASK, 32'h8);
    port("irq", 1'b1, irq);
    wr(sfp_pkg::OFF_CTRL, 32'h2);
    port("pin", 1'b0, pulse_output_pin);
    repeat (2 * per) @(posedge clk);
    chk("pin idle", 1'b0, pulse_output_pin);
    rd(sfp_pkg::OFF_STATUS, 32'hF);
    wr(sfp_pkg::OFF_STATUS, 32'hF);
    rd(sfp_pkg::OFF_STATUS, 32'h1);
    wr(sfp_pkg::OFF_CTRL, 32'hA);
    port("pin", 1'b1, pulse_output_pin);
    wr(sfp_pkg::OFF_CTRL, 32'h2);
    $display("test pwm_bus_clock done");
    for (int s = 2; s < 4; s++) begin
      t = (s == 2 ? 5 : 7) * 2;
      wr(sfp_pkg::OFF_CTRL, 32'(s << 1));
      wr(sfp_pkg::OFF_PRESC, 32'h1);
      wr(sfp_pkg::OFF_PERIOD, 32'h2);
      wr(sfp_pkg::OFF_SAMPLE, 32'h1);
      pw_q.push_back('{t, 2 * t});
      pw_q.push_back('{t, 2 * t});
      low_power <= 1'b1;
      wr(sfp_pkg::OFF_CTRL, 32'((s << 1) | 1));
      drain();
      wr(sfp_pkg::OFF_CTRL, 32'(s << 1));
      low_power <= 1'b0;
    end
    $display("test other_sources done");
    finish_test();
  end
endmodule : tb_sfp_top
